// ===== hdl/fifo_ctrl_consts.svh
// Register offsets, field positions, FIFO depth, source codes and response codes for the FIFO control block
// Behaviour
// - Writing transmit flush empties transmit FIFO and count; shifter untouched; bit self-clears.
// - Writing receive flush empties receive FIFO and count; shifter untouched; bit self-clears.
// - FIFO enable one turns both FIFOs on; zero (reset) means single-register mode.
// - Other setup bits are ignored unless the same write sets FIFO enable.
// - Receive trigger bits 7:6 select 8, 16, 24 or 28 bytes.
// - Transmit trigger bits 5:4 select 16, 8, 24 or 30 bytes.
// - Six prioritised levels; a status read shows only the highest pending one.
// - Receiver line status is level 1, code 000110.
// - Data ready and time-out are level 2, codes 000100 and 001100.
// - Transmit empty is level 3 code 000010; modem change level 4 code 000000.
// - Xoff or special character is level 5, shown by bit 4 alone.
// - CTS/RTS change is level 6, shown by bit 5 alone.
// - Status bits 7:6 read one while FIFOs enabled, otherwise zero.
// - Status bits 5:4 work only while enhanced-feature bit 4 is one.
// - Xoff status bit stays set until Xon characters arrive.
// - Status bit 0 reads zero while anything is pending, else one.
// - Receive interrupt while stored count is at or above trigger; FIFO fills until full.
// - Transmit interrupt when transmit count falls below trigger level.
`ifndef FIFO_CTRL_CONSTS_SVH
`define FIFO_CTRL_CONSTS_SVH
`define OFF_FIFO_SETUP       8'h00
`define OFF_INTERRUPT_SOURCE 8'h04
`define OFF_ENHANCED         8'h08
`define OFF_STATE            8'h0c
`define OFF_IRQ_STATUS       8'h10
`define OFF_IRQ_ENABLE       8'h14
`define OFF_IRQ_CLEAR        8'h18
`define BIT_FIFO_EN          0
`define BIT_RX_FLUSH         1
`define BIT_TX_FLUSH         2
`define BIT_DMA_MODE         3
`define BIT_EFR_ENH          4
`define FIFO_DEPTH           6'h20
`define SRC_LINE             8'h06
`define SRC_RX_DATA          8'h04
`define SRC_RX_TIMEOUT       8'h0c
`define SRC_TX_EMPTY         8'h02
`define SRC_MODEM            8'h00
`define SRC_XOFF             8'h10
`define SRC_FLOW             8'h20
`define SRC_NONE             8'h01
`define SRC_FIFO_ON          8'hc0
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10
`endif

// ===== hdl/fifo_ctrl_pkg.sv
// Types shared by the FIFO control block
package fifo_ctrl_pkg;
	typedef logic [5:0] count_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_RESP = 2'b01
	} rd_state_e;
endpackage

// ===== hdl/uart_fifo_ctrl.sv
// FIFO setup and prioritised interrupt identification for one UART channel
`timescale 1ns/1ns
`include "fifo_ctrl_consts.svh"
module uart_fifo_ctrl (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        line_status_event,
	input  wire logic        rx_timeout_event,
	input  wire logic        modem_status_event,
	input  wire logic        xoff_detect,
	input  wire logic        xon_detect,
	input  wire logic        flow_change_event,
	input  wire logic        rx_push,
	input  wire logic        rx_pop,
	input  wire logic        tx_push,
	input  wire logic        tx_pop,
	output logic             fifo_enable,
	output logic             dma_mode,
	output logic             rx_flush,
	output logic             tx_flush,
	output logic [5:0]       rx_count,
	output logic [5:0]       tx_count,
	output logic             rx_full,
	output logic             tx_full,
	output logic             irq
);
	logic        rst_meta_reg;
	logic        rst_sync_reg;
	logic        rst_n;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	// Reset asserts at once but always leaves on a clock edge, so no flop sees a torn release
	assign rst_n = rst_sync_reg;

	// Event inputs come from the serial side on this clock; no synchroniser needed
	function automatic fifo_ctrl_pkg::count_t rx_level(input logic [1:0] sel);
		case (sel)
			2'b00:   rx_level = 6'h08;
			2'b01:   rx_level = 6'h10;
			2'b10:   rx_level = 6'h18;
			default: rx_level = 6'h1c;
		endcase
	endfunction
	function automatic fifo_ctrl_pkg::count_t tx_level(input logic [1:0] sel);
		case (sel)
			2'b00:   tx_level = 6'h10;
			2'b01:   tx_level = 6'h08;
			2'b10:   tx_level = 6'h18;
			default: tx_level = 6'h1e;
		endcase
	endfunction

	// Write channel: address and data taken in either order, answered together
	logic        aw_held_reg, aw_held_next;
	logic [7:0]  aw_addr_reg, aw_addr_next;
	logic        w_held_reg, w_held_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0]  w_strb_reg, w_strb_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        wr_fire;
	logic        wr_hit_low;
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_hit_low    = wr_fire && w_strb_reg[0];
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	always_comb begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			case (aw_addr_reg)
				`OFF_FIFO_SETUP, `OFF_ENHANCED, `OFF_IRQ_ENABLE, `OFF_IRQ_CLEAR: begin
					bresp_next = `RESP_OKAY;
				end
				default: begin
					bresp_next = `RESP_SLVERR;
				end
			endcase
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'b00;
		end else begin
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg  <= w_held_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	// Setup, enhanced-feature, counters and interrupt flags
	logic       fifo_en_reg, fifo_en_next;
	logic       dma_reg, dma_next;
	logic [1:0] rx_trig_reg, rx_trig_next;
	logic [1:0] tx_trig_reg, tx_trig_next;
	logic       rx_flush_reg, rx_flush_next;
	logic       tx_flush_reg, tx_flush_next;
	logic       enh_reg, enh_next;
	logic [5:0] rx_cnt_reg, rx_cnt_next;
	logic [5:0] tx_cnt_reg, tx_cnt_next;
	logic       line_reg, line_next;
	logic       tmo_reg, tmo_next;
	logic       modem_reg, modem_next;
	logic       xoff_reg, xoff_next;
	logic       flow_reg, flow_next;
	logic       tx_ack_reg, tx_ack_next;
	logic [6:0] ist_reg, ist_next;
	logic [6:0] ien_reg, ien_next;
	logic [6:0] ev;
	logic       src_read;
	logic [7:0] src_code;
	logic       rx_hit, tx_low;

	// Writing the setup register with enable clear turns FIFOs off and, if they were on, empties both counts; other bits ignored
	wire setup_wr = wr_hit_low && aw_addr_reg == `OFF_FIFO_SETUP;
	wire en_bit   = w_data_reg[`BIT_FIFO_EN];
	wire [5:0] rx_cap = fifo_en_reg ? `FIFO_DEPTH : 6'h01;
	wire [5:0] tx_cap = fifo_en_reg ? `FIFO_DEPTH : 6'h01;

	assign rx_hit = fifo_en_reg ? (rx_cnt_reg >= rx_level(rx_trig_reg))
	                            : (rx_cnt_reg != 6'h00);
	assign tx_low = fifo_en_reg ? (tx_cnt_reg < tx_level(tx_trig_reg))
	                            : (tx_cnt_reg == 6'h00);

	always_comb begin
		fifo_en_next  = fifo_en_reg;
		dma_next      = dma_reg;
		rx_trig_next  = rx_trig_reg;
		tx_trig_next  = tx_trig_reg;
		rx_flush_next = 1'b0;
		tx_flush_next = 1'b0;
		enh_next      = enh_reg;
		if (setup_wr) begin
			fifo_en_next = en_bit;
			if (en_bit) begin
				dma_next      = w_data_reg[`BIT_DMA_MODE];
				rx_trig_next  = w_data_reg[7:6];
				tx_trig_next  = w_data_reg[5:4];
				rx_flush_next = w_data_reg[`BIT_RX_FLUSH];
				tx_flush_next = w_data_reg[`BIT_TX_FLUSH];
			end
		end
		if (wr_hit_low && aw_addr_reg == `OFF_ENHANCED) begin
			enh_next = w_data_reg[`BIT_EFR_ENH];
		end
		// Flush only clears the FIFO count; the shift registers live outside
		rx_cnt_next = rx_cnt_reg;
		if (rx_flush_reg || (setup_wr && en_bit != fifo_en_reg)) begin
			rx_cnt_next = 6'h00;
		end else if (rx_push && !rx_pop && rx_cnt_reg < rx_cap) begin
			rx_cnt_next = rx_cnt_reg + 6'h01;
		end else if (rx_pop && !rx_push && rx_cnt_reg != 6'h00) begin
			rx_cnt_next = rx_cnt_reg - 6'h01;
		end
		tx_cnt_next = tx_cnt_reg;
		if (tx_flush_reg || (setup_wr && en_bit != fifo_en_reg)) begin
			tx_cnt_next = 6'h00;
		end else if (tx_push && !tx_pop && tx_cnt_reg < tx_cap) begin
			tx_cnt_next = tx_cnt_reg + 6'h01;
		end else if (tx_pop && !tx_push && tx_cnt_reg != 6'h00) begin
			tx_cnt_next = tx_cnt_reg - 6'h01;
		end
	end

	// Source flags: reading the source register services the reported one, except data ready and Xoff
	always_comb begin
		line_next  = line_reg;
		tmo_next   = tmo_reg;
		modem_next = modem_reg;
		xoff_next  = xoff_reg;
		flow_next  = flow_reg;
		if (src_read) begin
			case (src_code & 8'h3f)
				`SRC_LINE:   line_next  = 1'b0;
				`SRC_RX_TIMEOUT: tmo_next = 1'b0;
				`SRC_MODEM:  modem_next = 1'b0;
				`SRC_FLOW:   flow_next  = 1'b0;
				default:     line_next  = line_reg;
			endcase
		end
		// Set wins over the read-clear in the same cycle
		if (line_status_event)  line_next  = 1'b1;
		if (rx_timeout_event)   tmo_next   = 1'b1;
		if (modem_status_event) modem_next = 1'b1;
		if (flow_change_event)  flow_next  = 1'b1;
		if (xon_detect)  xoff_next = 1'b0;
		if (xoff_detect) xoff_next = 1'b1;
		if (rx_cnt_next == 6'h00) tmo_next = 1'b0;
		// Transmit empty is serviced by a read until new data lands
		tx_ack_next = tx_ack_reg;
		if (src_read && (src_code & 8'h3f) == `SRC_TX_EMPTY) tx_ack_next = 1'b1;
		if (tx_push || !tx_low) tx_ack_next = 1'b0;
	end

	// Status code: strict priority, one level shown at a time
	always_comb begin
		src_code = `SRC_NONE;
		if (line_reg) src_code = `SRC_LINE;
		else if (rx_hit) src_code = `SRC_RX_DATA;
		else if (tmo_reg) src_code = `SRC_RX_TIMEOUT;
		else if (tx_low && !tx_ack_reg) src_code = `SRC_TX_EMPTY;
		else if (modem_reg) src_code = `SRC_MODEM;
		else if (enh_reg && xoff_reg) src_code = `SRC_XOFF;
		else if (enh_reg && flow_reg) src_code = `SRC_FLOW;
		if (fifo_en_reg) src_code = src_code | `SRC_FIFO_ON;
	end

	// Block-level interrupt: one sticky bit per source
	assign ev = {flow_change_event, xoff_detect, modem_status_event,
	             tx_low && !tx_ack_reg, rx_timeout_event, rx_hit, line_status_event};
	always_comb begin
		ist_next = ist_reg;
		ien_next = ien_reg;
		if (wr_hit_low && aw_addr_reg == `OFF_IRQ_CLEAR) ist_next = ist_reg & ~w_data_reg[6:0];
		if (wr_hit_low && aw_addr_reg == `OFF_IRQ_ENABLE) ien_next = w_data_reg[6:0];
		ist_next = ist_next | ev;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_en_reg <= 1'b0;
			dma_reg <= 1'b0;
			rx_trig_reg <= 2'b00;
			tx_trig_reg <= 2'b00;
			rx_flush_reg <= 1'b0;
			tx_flush_reg <= 1'b0;
			enh_reg <= 1'b0;
			rx_cnt_reg <= 6'h00;
			tx_cnt_reg <= 6'h00;
			line_reg <= 1'b0;
			tmo_reg <= 1'b0;
			modem_reg <= 1'b0;
			xoff_reg <= 1'b0;
			flow_reg <= 1'b0;
			tx_ack_reg <= 1'b0;
			ist_reg <= 7'h00;
			ien_reg <= 7'h00;
		end else begin
			fifo_en_reg <= fifo_en_next;
			dma_reg <= dma_next;
			rx_trig_reg <= rx_trig_next;
			tx_trig_reg <= tx_trig_next;
			rx_flush_reg <= rx_flush_next;
			tx_flush_reg <= tx_flush_next;
			enh_reg <= enh_next;
			rx_cnt_reg <= rx_cnt_next;
			tx_cnt_reg <= tx_cnt_next;
			line_reg <= line_next;
			tmo_reg <= tmo_next;
			modem_reg <= modem_next;
			xoff_reg <= xoff_next;
			flow_reg <= flow_next;
			tx_ack_reg <= tx_ack_next;
			ist_reg <= ist_next;
			ien_reg <= ien_next;
		end
	end

	assign fifo_enable = fifo_en_reg;
	assign dma_mode    = dma_reg;
	assign rx_flush    = rx_flush_reg;
	assign tx_flush    = tx_flush_reg;
	assign rx_count    = rx_cnt_reg;
	assign tx_count    = tx_cnt_reg;
	assign rx_full     = rx_cnt_reg == rx_cap;
	assign tx_full     = tx_cnt_reg == tx_cap;
	assign irq         = |(ist_reg & ien_reg);

	// Read channel
	fifo_ctrl_pkg::rd_state_e rd_state_reg, rd_state_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	assign s_axi_arready = rd_state_reg == fifo_ctrl_pkg::RD_IDLE;
	assign s_axi_rvalid  = rd_state_reg == fifo_ctrl_pkg::RD_RESP;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign src_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_INTERRUPT_SOURCE;

	always_comb begin
		rd_state_next = rd_state_reg;
		rdata_next    = rdata_reg;
		rresp_next    = rresp_reg;
		case (rd_state_reg)
			fifo_ctrl_pkg::RD_IDLE: begin
				if (s_axi_arvalid) begin
					rd_state_next = fifo_ctrl_pkg::RD_RESP;
					rresp_next    = `RESP_OKAY;
					case (s_axi_araddr)
						`OFF_FIFO_SETUP:       rdata_next = 32'h00000000;
						`OFF_INTERRUPT_SOURCE: rdata_next = {24'h000000, src_code};
						`OFF_ENHANCED:         rdata_next = {27'h0, enh_reg, 4'h0};
						`OFF_STATE:            rdata_next = {12'h000, tx_cnt_reg, 2'b00,
						                       rx_cnt_reg, tx_trig_reg, rx_trig_reg,
						                       dma_reg, fifo_en_reg};
						`OFF_IRQ_STATUS:       rdata_next = {25'h0, ist_reg};
						`OFF_IRQ_ENABLE:       rdata_next = {25'h0, ien_reg};
						`OFF_IRQ_CLEAR:        rdata_next = 32'h00000000;
						default: begin
							rdata_next = 32'h00000000;
							rresp_next = `RESP_SLVERR;
						end
					endcase
				end
			end
			fifo_ctrl_pkg::RD_RESP: begin
				if (s_axi_rready) rd_state_next = fifo_ctrl_pkg::RD_IDLE;
			end
			default: rd_state_next = fifo_ctrl_pkg::RD_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_state_reg <= fifo_ctrl_pkg::RD_IDLE;
			rdata_reg    <= 32'h00000000;
			rresp_reg    <= 2'b00;
		end else begin
			rd_state_reg <= rd_state_next;
			rdata_reg    <= rdata_next;
			rresp_reg    <= rresp_next;
		end
	end
endmodule

// ===== verif/axil_host.sv
// Host CPU model: AXI4-Lite master for the register port
`timescale 1ns/1ns
module axil_host (
	input  wire logic        core_clk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// Response readies stay high so no task ever lowers one in the step where the next starts
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arvalid} = '0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
endmodule

// ===== verif/fifo_ctrl_properties.sv
// Port-level checker for the FIFO setup and interrupt identification block
`timescale 1ns/1ns
module fifo_ctrl_checker (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        rx_push,
	input wire logic        rx_pop,
	input wire logic        fifo_enable,
	input wire logic        dma_mode,
	input wire logic        rx_flush,
	input wire logic        tx_flush,
	input wire logic [5:0]  rx_count,
	input wire logic [5:0]  tx_count,
	input wire logic        rx_full,
	input wire logic        tx_full
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_rx_flush_pulse:
	assert property (rx_flush |=> !rx_flush) else $error("rx flush held");
	a_tx_flush_pulse:
	assert property (tx_flush |=> !tx_flush) else $error("tx flush held");
	a_rx_flush_empty:
	assert property (rx_flush |-> ##[0:1] rx_count == 6'h00) else $error("rx not emptied");
	a_tx_flush_empty:
	assert property (tx_flush |-> ##[0:1] tx_count == 6'h00) else $error("tx not emptied");
	a_rx_full_level:
	assert property (rx_full == (rx_count == (fifo_enable ? 6'h20 : 6'h01)))
		else $error("rx full wrong");
	a_tx_full_level:
	assert property (tx_full == (tx_count == (fifo_enable ? 6'h20 : 6'h01)))
		else $error("tx full wrong");
	a_rx_count_up:
	assert property (fifo_enable && rx_push && !rx_pop && !rx_full && !rx_flush
		|=> rx_count == $past(rx_count) + 6'h01) else $error("rx push lost");
	a_rx_full_keep:
	assert property (rx_full && rx_push && !rx_pop && !rx_flush |=> rx_full)
		else $error("full dropped");
	a_dma_with_en:
	assert property ($rose(dma_mode) |-> fifo_enable) else $error("dma set without enable");
	a_read_answer:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");

	cover property (rx_full && fifo_enable);
	cover property (tx_flush);
	cover property (rx_full && !fifo_enable);
endmodule

bind uart_fifo_ctrl fifo_ctrl_checker u_chk (.core_clk, .arst_n, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .rx_push, .rx_pop, .fifo_enable, .dma_mode, .rx_flush, .tx_flush,
	.rx_count, .tx_count, .rx_full, .tx_full);

// ===== verif/tb.sv
// Self-checking bench for the FIFO setup and interrupt identification block
`timescale 1ns/1ns
`include "fifo_ctrl_consts.svh"
module tb;
	logic        core_clk, arst_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        line_status_event, rx_timeout_event, modem_status_event, xoff_detect;
	logic        xon_detect, flow_change_event, rx_push, rx_pop, tx_push, tx_pop;
	logic        fifo_enable, dma_mode, rx_flush, tx_flush, rx_full, tx_full, irq;
	logic [5:0]  rx_count, tx_count;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic [9:0]  drv;
	localparam logic [9:0] m_line = 10'h200, m_tmo = 10'h100, m_modem = 10'h080;
	localparam logic [9:0] m_xoff = 10'h040, m_xon = 10'h020, m_flow = 10'h010;
	localparam logic [9:0] m_rx_push = 10'h008, m_rx_pop = 10'h004;
	localparam logic [9:0] m_tx_push = 10'h002, m_tx_pop = 10'h001;

	// One vector drives every event and FIFO strobe, so one task can pulse any of them
	assign {line_status_event, rx_timeout_event, modem_status_event, xoff_detect, xon_detect,
	        flow_change_event, rx_push, rx_pop, tx_push, tx_pop} = drv;

	uart_fifo_ctrl u_dut (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_status_event, .rx_timeout_event,
		.modem_status_event, .xoff_detect, .xon_detect, .flow_change_event, .rx_push, .rx_pop,
		.tx_push, .tx_pop, .fifo_enable, .dma_mode, .rx_flush, .tx_flush, .rx_count,
		.tx_count, .rx_full, .tx_full, .irq);
	axil_host u_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
		logic [1:0] r;
		u_host.wr(a, d, r);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input logic [1:0] er = 2'b00);
		logic [31:0] d;
		logic [1:0]  r;
		u_host.rd(a, d, r);
		chk(d & m, e);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic pulse(input logic [9:0] m, input int n);
		repeat (n) begin
			drv <= m;
			@(posedge core_clk);
			drv <= 10'h000;
			@(posedge core_clk);
		end
	endtask

	// Registered flags need a couple of edges before they can be sampled safely
	task automatic settle;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic t_setup;
		chk({31'h0, fifo_enable}, 32'h0);
		rd(`OFF_INTERRUPT_SOURCE, 32'hc0, 32'h0);
		wr(`OFF_FIFO_SETUP, 32'hf8);
		rd(`OFF_STATE, 32'h3f, 32'h0);
		wr(`OFF_FIFO_SETUP, 32'h09);
		chk({30'h0, fifo_enable, dma_mode}, 32'h3);
		rd(`OFF_INTERRUPT_SOURCE, 32'hc0, 32'hc0);
		$display("test setup done");
	endtask

	task automatic t_rx_trig;
		int lvl[4] = '{8, 16, 24, 28};
		for (int k = 0; k < 4; k++) begin
			wr(`OFF_FIFO_SETUP, 32'h03 | (32'(k) << 6));
			// The count empties on the edge after the write is answered
			@(posedge core_clk);
			chk({26'h0, rx_count}, 32'h0);
			pulse(m_rx_push, lvl[k] - 1);
			wr(`OFF_IRQ_CLEAR, 32'h02);
			rd(`OFF_IRQ_STATUS, 32'h02, 32'h0);
			pulse(m_rx_push, 1);
			rd(`OFF_IRQ_STATUS, 32'h02, 32'h02);
		end
		pulse(m_rx_push, 5);
		settle();
		chk({25'h0, rx_full, rx_count}, 32'h60);
		$display("test rx_trig done");
	endtask

	task automatic t_tx_trig;
		int lvl[4] = '{16, 8, 24, 30};
		for (int k = 0; k < 4; k++) begin
			wr(`OFF_FIFO_SETUP, 32'h05 | (32'(k) << 4));
			@(posedge core_clk);
			chk({26'h0, tx_count}, 32'h0);
			pulse(m_tx_push, lvl[k]);
			wr(`OFF_IRQ_CLEAR, 32'h08);
			rd(`OFF_IRQ_STATUS, 32'h08, 32'h0);
			pulse(m_tx_pop, 1);
			rd(`OFF_IRQ_STATUS, 32'h08, 32'h08);
		end
		$display("test tx_trig done");
	endtask

	task automatic t_prio;
		pulse(m_tx_push, 1);
		wr(`OFF_FIFO_SETUP, 32'h07);
		wr(`OFF_ENHANCED, 32'h10);
		pulse(m_rx_push, 8);
		pulse(m_line, 1);
		pulse(m_modem, 1);
		pulse(m_xoff, 1);
		pulse(m_flow, 1);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hc6);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hc4);
		pulse(m_rx_pop, 1);
		pulse(m_tmo, 1);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hcc);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hc2);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hc0);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hd0);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hd0);
		pulse(m_xon, 1);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'he0);
		rd(`OFF_INTERRUPT_SOURCE, 32'hff, 32'hc1);
		wr(`OFF_ENHANCED, 32'h0);
		pulse(m_flow, 1);
		rd(`OFF_INTERRUPT_SOURCE, 32'h30, 32'h0);
		$display("test prio done");
	endtask

	task automatic t_irq;
		wr(`OFF_IRQ_CLEAR, 32'h7f);
		wr(`OFF_IRQ_ENABLE, 32'h01);
		pulse(m_line, 1);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(`OFF_IRQ_ENABLE, 32'h0);
		settle();
		chk({31'h0, irq}, 32'h0);
		wr(`OFF_IRQ_ENABLE, 32'h01);
		rd(`OFF_IRQ_STATUS, 32'h01, 32'h01);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(`OFF_IRQ_CLEAR, 32'h01);
		settle();
		chk({31'h0, irq}, 32'h0);
		rd(8'h1c, 32'hffffffff, 32'h0, `RESP_SLVERR);
		wr(`OFF_IRQ_STATUS, 32'h01, `RESP_SLVERR);
		wr(`OFF_FIFO_SETUP, 32'h00);
		pulse(m_rx_push, 1);
		settle();
		chk({31'h0, rx_full}, 32'h1);
		rd(`OFF_INTERRUPT_SOURCE, 32'hc0, 32'h0);
		$display("test irq done");
	endtask

	initial begin
		arst_n = 1'b0;
		drv = 10'h000;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_setup();
		t_rx_trig();
		t_tx_trig();
		t_prio();
		t_irq();
		test_done();
	end
endmodule
